// file: shared/dacsw_pkg.sv
// Purpose: Constants for the serial write port of a 12-bit converter
// Assumes: Serial pins sampled by clk_i at 100 MHz
// Notes: Word is 2 ignored bits, 2 mode bits, 12 data bits, MSB first
// Behaviour
// - Incoming bits go into a sixteen-bit shift register filled before any action.
// - Data is sampled on each falling serial clock edge.
// - Frame sync is active low; shifting is enabled only while low.
// - After the sixteenth falling edge, load converter code and mode.
// - Frame sync rising before sixteen edges aborts; nothing changes.
// - Converter code is twelve-bit straight binary, 000 to FFF.
// - Word is MSB first: two ignored bits, two mode bits, twelve data.
// - Mode 00 normal, 01 1k down, 10 100k down, 11 high-impedance down.
// - Reset clears converter code to zero until first complete frame.
// - Power-down frames still load the converter code from the twelve data bits.
package dacsw_pkg;
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned CODE_BITS = 12;
    localparam int unsigned MODE_HI_POS = 13;
    localparam int unsigned MODE_LO_POS = 12;
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PD_1K = 2'h1;
    localparam logic [1:0] MODE_PD_100K = 2'h2;
    localparam logic [1:0] MODE_PD_HIZ = 2'h3;
    localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
    localparam logic [1:0] PIN_IDLE_RESET = 2'h3;
endpackage

// file: core/dacsw_port.sv
// Purpose: Serial write port, converter code and mode registers
// Assumes: Serial clock slower than a quarter of clk_i
// Notes: Pins pass two flip-flops before use; outputs are registered
`timescale 1ns/10ps
module dacsw_port (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic sync_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    output logic [11:0] dac_code_o,
    output logic [1:0] op_mode_o,
    output logic power_down_o,
    output logic update_o
);
    // ------------------------------------------------
    // State
    // ------------------------------------------------
    typedef enum logic [2:0] {
        DACSW_IDLE = 3'b001,
        DACSW_SHIFT = 3'b010,
        DACSW_DONE = 3'b100
    } dacsw_state_e;

    typedef struct packed {
        logic [1:0] sync_m;
        logic [1:0] sclk_m;
        logic [1:0] din_m;
        logic sclk_prev;
        dacsw_state_e st;
        logic [15:0] shreg;
        logic [4:0] cnt;
        logic [11:0] code;
        logic [1:0] mode;
        logic pd;
        logic upd;
    } dacsw_s;

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    // Bit counter step
    function automatic logic [4:0] dacsw_inc(input logic [4:0] cnt);
        return cnt + 5'h01;
    endfunction

    // Twelve data bits of a received word
    function automatic logic [11:0] dacsw_code_of(input logic [15:0] word);
        return word[dacsw_pkg::CODE_BITS-1:0];
    endfunction

    // Two mode bits of a received word
    function automatic logic [1:0] dacsw_mode_of(input logic [15:0] word);
        return word[dacsw_pkg::MODE_HI_POS:dacsw_pkg::MODE_LO_POS];
    endfunction

    // Any mode but normal powers the output stage down
    function automatic logic dacsw_is_pd(input logic [1:0] mode);
        return mode != dacsw_pkg::MODE_NORMAL;
    endfunction

    dacsw_s s_q;
    dacsw_s s_d;
    logic sync_n;
    logic sclk_fall;
    logic [15:0] word_in;
    logic [4:0] cnt_inc;

    assign sync_n = s_q.sync_m[1];
    assign sclk_fall = s_q.sclk_prev & ~s_q.sclk_m[1];
    // Word as it stands once the current data bit is shifted in
    assign word_in = {s_q.shreg[dacsw_pkg::WORD_BITS-2:0], s_q.din_m[1]};
    assign cnt_inc = dacsw_inc(s_q.cnt);

    // ------------------------------------------------
    // Next state
    // ------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.sync_m = {s_q.sync_m[0], sync_n_i};
        s_d.sclk_m = {s_q.sclk_m[0], sclk_i};
        s_d.din_m = {s_q.din_m[0], din_i};
        s_d.sclk_prev = s_q.sclk_m[1];
        s_d.upd = 1'b0;
        unique case (s_q.st)
            DACSW_IDLE: begin
                s_d.cnt = 5'h00;
                if (!sync_n) begin
                    s_d.st = DACSW_SHIFT;
                end
            end
            DACSW_SHIFT: begin
                if (sync_n) begin
                    s_d.st = DACSW_IDLE;
                    s_d.shreg = 16'h0000;
                    s_d.cnt = 5'h00;
                end else if (sclk_fall) begin
                    s_d.shreg = word_in;
                    s_d.cnt = cnt_inc;
                    if (cnt_inc == dacsw_pkg::BIT_COUNT_FULL) begin
                        s_d.code = dacsw_code_of(word_in);
                        s_d.mode = dacsw_mode_of(word_in);
                        s_d.pd = dacsw_is_pd(dacsw_mode_of(word_in));
                        s_d.upd = 1'b1;
                        s_d.st = DACSW_DONE;
                    end
                end
            end
            DACSW_DONE: begin
                if (sync_n) begin
                    s_d.st = DACSW_IDLE;
                end
            end
            default: s_d.st = DACSW_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            // Sync and clock pin stages start at the idle-high level, so no false edge follows reset
            s_q <= '{sync_m: dacsw_pkg::PIN_IDLE_RESET,
                     sclk_m: dacsw_pkg::PIN_IDLE_RESET,
                     din_m: 2'h0,
                     sclk_prev: 1'b1,
                     st: DACSW_IDLE,
                     shreg: 16'h0000,
                     cnt: 5'h00,
                     code: dacsw_pkg::CODE_RESET,
                     mode: dacsw_pkg::MODE_NORMAL,
                     pd: 1'b0,
                     upd: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign dac_code_o = s_q.code;
    assign op_mode_o = s_q.mode;
    assign power_down_o = s_q.pd;
    assign update_o = s_q.upd;

    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    property p_abort_keeps;
        @(posedge clk_i) disable iff (reset_i)
        (s_q.st == DACSW_SHIFT && sync_n) |=> $stable(dac_code_o) && $stable(op_mode_o);
    endproperty
    a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed output");

    property p_update_count;
        @(posedge clk_i) disable iff (reset_i)
        update_o |-> $past(s_q.cnt) == 5'h0F;
    endproperty
    a_update_count: assert property (p_update_count) else $error("update not at 16th");

    property p_no_change_without_update;
        @(posedge clk_i) disable iff (reset_i)
        !update_o |-> $stable(dac_code_o);
    endproperty
    a_no_change_without_update: assert property (p_no_change_without_update)
        else $error("code changed without update");

    property p_done_ignores;
        @(posedge clk_i) disable iff (reset_i)
        (s_q.st == DACSW_DONE) |=> !update_o;
    endproperty
    a_done_ignores: assert property (p_done_ignores) else $error("extra update");

    property p_pd_matches;
        @(posedge clk_i) disable iff (reset_i)
        power_down_o == (op_mode_o != dacsw_pkg::MODE_NORMAL);
    endproperty
    a_pd_matches: assert property (p_pd_matches) else $error("power down flag wrong");

    property p_shift_only_low;
        @(posedge clk_i) disable iff (reset_i)
        (s_q.st == DACSW_IDLE) |=> s_q.cnt == 5'h00;
    endproperty
    a_shift_only_low: assert property (p_shift_only_low) else $error("count in idle");

    property p_shift_on_fall;
        @(posedge clk_i) disable iff (reset_i)
        (s_q.st == DACSW_SHIFT && !sync_n && !sclk_fall) |=> $stable(s_q.cnt);
    endproperty
    a_shift_on_fall: assert property (p_shift_on_fall) else $error("shift without edge");

    property p_update_data;
        @(posedge clk_i) disable iff (reset_i)
        update_o |-> dac_code_o == {$past(s_q.shreg[10:0]), $past(s_q.din_m[1])};
    endproperty
    a_update_data: assert property (p_update_data) else $error("wrong code loaded");

    property p_reset_zero;
        @(posedge clk_i) $past(reset_i) && !reset_i |-> dac_code_o == 12'h000;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("code not zero at reset");

    property p_abort_clears;
        @(posedge clk_i) disable iff (reset_i)
        (s_q.st == DACSW_SHIFT && sync_n) |=> s_q.st == DACSW_IDLE && s_q.cnt == 5'h00
            && s_q.shreg == 16'h0000;
    endproperty
    a_abort_clears: assert property (p_abort_clears) else $error("abort left state");

    property p_start_low;
        @(posedge clk_i) disable iff (reset_i)
        (s_q.st == DACSW_IDLE && !sync_n) |=> s_q.st == DACSW_SHIFT;
    endproperty
    a_start_low: assert property (p_start_low) else $error("no start on low sync");

    property p_done_holds;
        @(posedge clk_i) disable iff (reset_i)
        (s_q.st == DACSW_DONE && !sync_n) |=> s_q.st == DACSW_DONE && $stable(s_q.cnt);
    endproperty
    a_done_holds: assert property (p_done_holds) else $error("done left early");

    property p_upd_last;
        @(posedge clk_i) disable iff (reset_i)
        (s_q.st == DACSW_SHIFT && !sync_n && sclk_fall && s_q.cnt == 5'h0F) |=> update_o;
    endproperty
    a_upd_last: assert property (p_upd_last) else $error("no update at 16th");

    property p_upd_pulse;
        @(posedge clk_i) disable iff (reset_i)
        update_o |=> !update_o;
    endproperty
    a_upd_pulse: assert property (p_upd_pulse) else $error("update too long");

    property p_mode_hold;
        @(posedge clk_i) disable iff (reset_i)
        !update_o |-> $stable(op_mode_o);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed alone");

    property p_pd_code;
        @(posedge clk_i) disable iff (reset_i)
        (update_o && power_down_o) |-> dac_code_o == dacsw_code_of($past(word_in));
    endproperty
    a_pd_code: assert property (p_pd_code) else $error("power down lost code");
endmodule

// file: dv/dacsw_host.sv
// Purpose: Host model that drives serial write frames
// Assumes: Link clock of 80 ns that idles high between frames
// Notes: The data line shows the inverse of its last bit outside frames
`timescale 1ns/10ps
module dacsw_host (
    output logic sync_n_o,
    output logic sclk_o,
    output logic din_o
);
    initial begin
        sync_n_o = 1'b1;
        sclk_o = 1'b1;
        din_o = 1'b0;
    end
    // Sends the first n bits of w, MSB first
    task automatic send(input logic [19:0] w, input int n);
        sync_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            din_o = w[19-i];
            #40 sclk_o = 1'b0;
            #40 sclk_o = 1'b1;
        end
        #40 sync_n_o = 1'b1;
        din_o = ~din_o;
        #80;
    endtask
endmodule

// file: dv/tb_top.sv
// Purpose: Random and corner frames into the serial write port
// Assumes: Host model drives the pins on falling clk_i edges
// Notes: Update pulses are counted per frame
`timescale 1ns/10ps
module tb_top;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic sync_n, sclk, din;
    logic [11:0] dac_code_o;
    logic [1:0] op_mode_o;
    logic power_down_o, update_o;
    int miscompares = 0;
    int checks = 0;
    int ups = 0;
    int seed = 32'hA098;
    logic [15:0] w;
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    dacsw_host host (.sync_n_o(sync_n), .sclk_o(sclk), .din_o(din));
    dacsw_port dut (.clk_i(clk_i), .reset_i(reset_i), .sync_n_i(sync_n), .sclk_i(sclk),
        .din_i(din), .dac_code_o(dac_code_o), .op_mode_o(op_mode_o),
        .power_down_o(power_down_o), .update_o(update_o));
    always @(posedge clk_i) begin
        if (update_o === 1'b1)
            ups++;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Expected outputs worked out from the expected word e given to frame, which is not the word sent for aborted frames
    function automatic logic [15:0] exp_code(input logic [15:0] word);
        return {4'h0, word[dacsw_pkg::CODE_BITS-1:0]};
    endfunction
    function automatic logic [15:0] exp_mode(input logic [15:0] word);
        return {14'h0, word[dacsw_pkg::MODE_HI_POS:dacsw_pkg::MODE_LO_POS]};
    endfunction
    function automatic logic [15:0] exp_pd(input logic [15:0] word);
        return {15'h0, word[13:12] != dacsw_pkg::MODE_NORMAL};
    endfunction
    // Sends a frame, then checks pulses and outputs against word e
    task automatic frame(input logic [19:0] f, input int n, input logic [15:0] e, input int nu);
        int u0;
        u0 = ups;
        host.send(f, n);
        chk("updates", 16'(ups - u0), 16'(nu));
        chk("code", {4'h0, dac_code_o}, exp_code(e));
        chk("mode", {14'h0, op_mode_o}, exp_mode(e));
        chk("pd", {15'h0, power_down_o}, exp_pd(e));
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        @(negedge clk_i) reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
        chk("code", {4'h0, dac_code_o}, 16'h0000);
        chk("mode", {14'h0, op_mode_o}, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            w = 16'($random(seed));
            if (i < 2)
                w = {2'(i * 3), 2'h0, {12{i[0]}}};
            frame({w, 4'h0}, 16, w, 1);
        end
        for (int m = 1; m < 4; m++)
            frame({2'h3, 2'(m), w[11:0], 4'h0}, 16, {2'h0, 2'(m), w[11:0]}, 1);
        frame({4'h0, ~w[11:0], 4'h0}, 15, {4'h3, w[11:0]}, 0);
        frame({w ^ 16'h0A5A, 4'hA}, 20, w ^ 16'h0A5A, 1);
        frame({16'h1ABC, 4'h0}, 16, 16'h1ABC, 1);
        @(negedge clk_i) reset_i = 1'b1;
        repeat (2) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
        chk("code", {4'h0, dac_code_o}, 16'h0000);
        chk("mode", {14'h0, op_mode_o}, 16'h0000);
        chk("pd", {15'h0, power_down_o}, 16'h0000);
        frame({16'h3FFF, 4'h0}, 8, 16'h0000, 0);
        frame({16'h0123, 4'h0}, 16, 16'h0123, 1);
        test_done();
    end
endmodule
